// *** core/smrb_mode_top.sv ***
// operating-mode setting register, command decode and burst addressing
`timescale 1ns/100ps
`include "smrb_defines.svh"
module smrb_mode_top
  import smrb_pkg::*;
(
  input  wire logic        CORE_CLK_I,    // device clock
  input  wire logic        SYS_RST_I,     // sync reset, active high
  input  wire logic        CE_I,          // clock enable
  input  wire logic        CS_N_I,        // chip select, low active
  input  wire logic        RAS_N_I,       // row strobe, low active
  input  wire logic        CAS_N_I,       // column strobe, low active
  input  wire logic        WE_N_I,        // write enable, low active
  input  wire logic [12:0] ADDR_I,        // address bits
  input  wire logic        STOP_I,        // terminating command seen
  output logic [12:0]      MODE_O,        // stored setting
  output logic [1:0]       LATENCY_O,     // read latency in clocks
  output logic             LOAD_BUSY_O,   // load-mode write in progress
  output logic             BURST_ACT_O,   // burst running
  output logic [8:0]       BURST_COL_O    // current burst column
);
  // pins pass three flops; a change counts when stages two and three agree
  logic [16:0] s1_ff, s2_ff, s3_ff, pin_ff;
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      s1_ff  <= 17'h0000F;
      s2_ff  <= 17'h0000F;
      s3_ff  <= 17'h0000F;
      pin_ff <= 17'h0000F;
    end else if (CE_I) begin
      s1_ff <= {ADDR_I, CS_N_I, RAS_N_I, CAS_N_I, WE_N_I};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff)
        pin_ff <= s3_ff;
    end
  end

  logic [12:0] addr;
  logic        cs_n, ras_n, cas_n, we_n;
  assign {addr, cs_n, ras_n, cas_n, we_n} = pin_ff;

  // command decode from the filtered pins
  function automatic smrb_cmd_e decode(input logic c, r, a, w);
    if (c)
      decode = SMRB_CMD_DESELECT;
    else
      case ({r, a, w})
        3'h0:    decode = SMRB_CMD_LOAD_MODE;
        3'h7:    decode = SMRB_CMD_NOP;
        3'h5:    decode = SMRB_CMD_READ;
        3'h4:    decode = SMRB_CMD_WRITE;
        default: decode = SMRB_CMD_OTHER;
      endcase
  endfunction

  smrb_cmd_e cmd;
  logic      pin_new_ff;
  // decode once per accepted change; a held level must not restart bursts
  assign cmd = pin_new_ff ? decode(cs_n, ras_n, cas_n, we_n) : SMRB_CMD_NOP;

  // marks the cycle after the filtered pins took a new value
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I)
      pin_new_ff <= 1'b0;
    else if (CE_I)
      pin_new_ff <= (s2_ff == s3_ff) && (s3_ff != pin_ff);
  end

  // setting register; reset gives a known value, power-up is undefined
  smrb_mode_t mode_ff;
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I)
      mode_ff <= `SMRB_MODE_RST;
    else if (CE_I && cmd == SMRB_CMD_LOAD_MODE)
      mode_ff <= addr;
  end

  // two-clock completion window for the load-mode write
  logic [1:0] busy_cnt_ff;
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I)
      busy_cnt_ff <= 2'h0;
    else if (CE_I) begin
      if (cmd == SMRB_CMD_LOAD_MODE)
        busy_cnt_ff <= 2'(`SMRB_LOAD_CYCLES);
      else if (busy_cnt_ff != 2'h0)
        busy_cnt_ff <= busy_cnt_ff - 2'h1;
    end
  end

  smrb_burst_if bif ();
  logic rw;
  assign rw = (cmd == SMRB_CMD_READ) || (cmd == SMRB_CMD_WRITE);
  // burst settings come from the stored register only
  assign bif.start     = CE_I && rw && busy_cnt_ff == 2'h0;
  assign bif.is_write  = (cmd == SMRB_CMD_WRITE);
  assign bif.col       = addr[8:0];
  assign bif.len_code  = mode_ff[`SMRB_BL_MSB:`SMRB_BL_LSB];
  assign bif.order     = mode_ff[`SMRB_ORDER_BIT];
  assign bif.single_wr = mode_ff[`SMRB_WBURST_BIT];

  smrb_burst_gen u_gen (
    .clk_i  (CORE_CLK_I),
    .rst_i  (SYS_RST_I),
    .ce_i   (CE_I),
    .stop_i (STOP_I),
    .bus    (bif.gen)
  );

  // registered outputs
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      MODE_O      <= 13'h0000;
      LATENCY_O   <= 2'h0;
      LOAD_BUSY_O <= 1'b0;
      BURST_ACT_O <= 1'b0;
      BURST_COL_O <= 9'h000;
    end else if (CE_I) begin
      MODE_O      <= mode_ff;
      case (mode_ff[`SMRB_LAT_MSB:`SMRB_LAT_LSB])
        `SMRB_LAT_2: LATENCY_O <= 2'h2;
        `SMRB_LAT_3: LATENCY_O <= 2'h3;
        default:     LATENCY_O <= 2'h0;
      endcase
      LOAD_BUSY_O <= (busy_cnt_ff != 2'h0);
      BURST_ACT_O <= bif.active;
      BURST_COL_O <= bif.cur_col;
    end
  end
endmodule // smrb_mode_top

// *** core/smrb_defines.svh ***
// constants for the operating-mode setting and burst address logic
`ifndef SMRB_DEFINES_SVH
`define SMRB_DEFINES_SVH
`define SMRB_ADDR_W       13
`define SMRB_COL_W        9
`define SMRB_PAGE_LAST    9'h1FF
`define SMRB_BL_LSB       0
`define SMRB_BL_MSB       2
`define SMRB_ORDER_BIT    3
`define SMRB_LAT_LSB      4
`define SMRB_LAT_MSB      6
`define SMRB_TEST_LSB     7
`define SMRB_TEST_MSB     8
`define SMRB_WBURST_BIT   9
`define SMRB_BL_1         3'h0
`define SMRB_BL_2         3'h1
`define SMRB_BL_4         3'h2
`define SMRB_BL_8         3'h3
`define SMRB_BL_PAGE      3'h7
`define SMRB_LAT_2        3'h2
`define SMRB_LAT_3        3'h3
`define SMRB_MODE_RST     13'h0000
`define SMRB_LOAD_CYCLES  2
`endif

// *** core/smrb_pkg.sv ***
// types shared by the operating-mode setting and burst address logic
package smrb_pkg;
  typedef logic [12:0] smrb_mode_t;
  typedef logic [8:0]  smrb_col_t;
  typedef enum logic [2:0] {
    SMRB_CMD_DESELECT,
    SMRB_CMD_NOP,
    SMRB_CMD_LOAD_MODE,
    SMRB_CMD_READ,
    SMRB_CMD_WRITE,
    SMRB_CMD_OTHER
  } smrb_cmd_e;
endpackage

// *** core/smrb_burst_if.sv ***
// carrier between the command decode and the burst address generator
`timescale 1ns/100ps
interface smrb_burst_if;
  logic      start;     // one-cycle burst start
  logic      is_write;  // burst is a write
  logic [8:0] col;      // start column
  logic [2:0] len_code; // burst length code
  logic      order;     // 1 interleaved
  logic      single_wr; // write bursts are one word
  logic      active;    // burst running
  logic [8:0] cur_col;  // current column
  modport ctl (output start, is_write, col, len_code, order, single_wr,
               input active, cur_col);
  modport gen (input start, is_write, col, len_code, order, single_wr,
               output active, cur_col);
endinterface

// *** core/smrb_burst_gen.sv ***
// burst column address generator
`timescale 1ns/100ps
`include "smrb_defines.svh"
module smrb_burst_gen
  import smrb_pkg::*;
(
  input  wire logic clk_i,   // core clock
  input  wire logic rst_i,   // sync reset
  input  wire logic ce_i,    // clock enable
  input  wire logic stop_i,  // terminating command
  smrb_burst_if.gen bus      // burst carrier
);
  logic [8:0] base_ff;
  logic [8:0] cnt_ff;
  logic [9:0] left_ff;
  logic       page_ff;
  logic       order_ff;
  logic [8:0] mask;
  logic [9:0] len;
  logic [8:0] blk_ff;

  // length in words for a code; reserved codes fall back to one word
  function automatic logic [9:0] bl_words(input logic [2:0] c);
    case (c)
      `SMRB_BL_1:    bl_words = 10'h001;
      `SMRB_BL_2:    bl_words = 10'h002;
      `SMRB_BL_4:    bl_words = 10'h004;
      `SMRB_BL_8:    bl_words = 10'h008;
      `SMRB_BL_PAGE: bl_words = 10'h200;
      default:       bl_words = 10'h001;
    endcase
  endfunction

  assign len  = bl_words(bus.len_code);
  // wrap mask comes from the length captured at start, not the live code
  assign mask = page_ff ? `SMRB_PAGE_LAST : blk_ff;

  // column: wrap inside aligned block, or xor with counter when interleaved and not full page
  always_comb begin
    logic [8:0] m;
    m = 9'h000;
    bus.cur_col = base_ff;
    m = mask;
    if (order_ff && !page_ff)
      bus.cur_col = (base_ff & ~m) | ((base_ff ^ cnt_ff) & m);
    else
      bus.cur_col = (base_ff & ~m) | ((base_ff + cnt_ff) & m);
  end

  // burst progress; a new burst restarts, full page runs until stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      base_ff  <= 9'h000;
      cnt_ff   <= 9'h000;
      left_ff  <= 10'h000;
      page_ff  <= 1'b0;
      order_ff <= 1'b0;
      bus.active <= 1'b0;
    end else if (ce_i) begin
      if (bus.start) begin
        base_ff    <= bus.col;
        cnt_ff     <= 9'h000;
        // a single-word write in page mode must still end after one word
        page_ff    <= (bus.len_code == `SMRB_BL_PAGE) &&
                      !(bus.is_write && bus.single_wr);
        order_ff   <= bus.order;
        left_ff    <= (bus.is_write && bus.single_wr) ? 10'h001 : len;
        bus.active <= 1'b1;
      end else if (stop_i) begin
        bus.active <= 1'b0;
      end else if (bus.active) begin
        cnt_ff <= cnt_ff + 9'h001;
        if (!page_ff) begin
          left_ff <= left_ff - 10'h001;
          if (left_ff == 10'h001)
            bus.active <= 1'b0;
        end
      end
    end
  end

  // block mask of the aligned burst; full page uses the whole column field
  always_ff @(posedge clk_i) begin
    if (rst_i)
      blk_ff <= 9'h000;
    else if (ce_i && bus.start)
      blk_ff <= 9'(len - 10'h001);
  end
endmodule // smrb_burst_gen

// *** test/smrb_ctl_model.sv ***
// command driver standing in for the memory controller
`timescale 1ns/100ps
module smrb_ctl_model (
  input  wire logic        clk_i,   // device clock
  output logic             cs_n_o,  // chip select
  output logic             ras_n_o, // row strobe
  output logic             cas_n_o, // column strobe
  output logic             we_n_o,  // write enable
  output logic [12:0]      addr_o   // address
);
  initial {cs_n_o, ras_n_o, cas_n_o, we_n_o, addr_o} = {4'hF, 13'h0000};
  // hold a command past the pin filter, then fill with no-operation;
  // the released address is inverted so a stale value never matches
  task automatic issue(input logic [3:0] cmd, input logic [12:0] a);
    @(negedge clk_i);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = cmd;
    addr_o = (cmd == 4'h0) ? (a & 13'h03FF) : a;
    repeat (5) @(negedge clk_i);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'h7;
    addr_o = ~a;
  endtask
endmodule // smrb_ctl_model

// *** test/smrb_mode_checker.sv ***
// assertions on the ports of the operating-mode setting block
`timescale 1ns/100ps
module smrb_mode_checker (
  input wire logic        CORE_CLK_I,  // clock
  input wire logic        SYS_RST_I,   // reset
  input wire logic [12:0] MODE_O,      // setting
  input wire logic [1:0]  LATENCY_O,   // latency
  input wire logic        LOAD_BUSY_O, // load busy
  input wire logic        BURST_ACT_O, // burst running
  input wire logic [8:0]  BURST_COL_O  // column
);
  logic       act_q;
  logic [8:0] col_q;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // previous column, so steps inside a burst can be compared
  always_ff @(posedge CORE_CLK_I) begin
    act_q <= BURST_ACT_O;
    col_q <= BURST_COL_O;
  end
  // reserved latency codes read back as zero
  function automatic logic [1:0] lat_of(input logic [12:0] m);
    return (m[6:4] == 3'h2) ? 2'h2 : ((m[6:4] == 3'h3) ? 2'h3 : 2'h0);
  endfunction
  sequence s_busy;
    LOAD_BUSY_O [*2] ##1 !LOAD_BUSY_O;
  endsequence
  sequence s_eight;
    BURST_ACT_O [*8] ##1 !BURST_ACT_O;
  endsequence
  wire run2 = BURST_ACT_O && act_q;
  a_reset_clear: assert property (disable iff (1'b0) SYS_RST_I |=>
    MODE_O == 13'h0000 && !LOAD_BUSY_O && !BURST_ACT_O)
    else $error("outputs not cleared by reset");
  a_busy_two: assert property ($rose(LOAD_BUSY_O) |-> s_busy)
    else $error("load busy not two cycles");
  a_mode_hold: assert property ($changed(MODE_O) |-> LOAD_BUSY_O ||
    $past(LOAD_BUSY_O) || $past(LOAD_BUSY_O, 2))
    else $error("setting changed without a load");
  a_lat_map: assert property (LATENCY_O == lat_of(MODE_O) ||
    LATENCY_O == lat_of($past(MODE_O)))
    else $error("latency does not follow setting");
  a_page_step: assert property (run2 && MODE_O[2:0] == 3'h7 |->
    BURST_COL_O == col_q + 9'h001)
    else $error("page burst did not step by one");
  a_seq4_step: assert property (run2 && MODE_O[3:0] == 4'h2 |->
    BURST_COL_O == {col_q[8:2], col_q[1:0] + 2'h1})
    else $error("sequential four burst wrong step");
  a_blk8_keep: assert property (run2 && MODE_O[2:0] == 3'h3 |->
    BURST_COL_O[8:3] == col_q[8:3])
    else $error("eight burst left its block");
  a_len1_one: assert property ($rose(BURST_ACT_O) &&
    MODE_O[2:0] == 3'h0 |=> !BURST_ACT_O)
    else $error("length one burst ran on");
  a_len8_count: assert property ($rose(BURST_ACT_O) &&
    MODE_O[2:0] == 3'h3 && !MODE_O[9] |-> s_eight)
    else $error("length eight burst wrong count");
endmodule // smrb_mode_checker
bind smrb_mode_top smrb_mode_checker u_chk (.CORE_CLK_I(CORE_CLK_I),
  .SYS_RST_I(SYS_RST_I), .MODE_O(MODE_O), .LATENCY_O(LATENCY_O),
  .LOAD_BUSY_O(LOAD_BUSY_O), .BURST_ACT_O(BURST_ACT_O),
  .BURST_COL_O(BURST_COL_O));

// *** test/sdram_mode_register_burst_bench.sv ***
// self-checking bench for the operating-mode setting and burst logic
`timescale 1ns/100ps
module sdram_mode_register_burst_bench;
  import smrb_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, stop = 1'b0, pg = 1'b0, ce = 1'b1;
  logic        cs_n, ras_n, cas_n, we_n, busy_o, act_o;
  logic [12:0] addr, mode_o, last_mode = 13'h0000;
  logic [1:0]  lat_o;
  logic [8:0]  col_o;
  logic [15:0] lfsr = 16'h2368;
  int          num_errors = 0, n_checks = 0;
  smrb_mode_t  cur, mq[$];
  smrb_col_t   cq[$];
  // test field always 00; latency 2 in three settings, latency 3 in the other four
  smrb_mode_t  modes[7] = '{13'h0020, 13'h0021, 13'h0032, 13'h002A,
                            13'h0033, 13'h003B, 13'h0237};
  always #2.5 clk = ~clk;
  smrb_ctl_model u_ctl (.clk_i(clk), .cs_n_o(cs_n), .ras_n_o(ras_n),
    .cas_n_o(cas_n), .we_n_o(we_n), .addr_o(addr));
  smrb_mode_top u_dut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce),
    .CS_N_I(cs_n), .RAS_N_I(ras_n), .CAS_N_I(cas_n), .WE_N_I(we_n),
    .ADDR_I(addr), .STOP_I(stop), .MODE_O(mode_o), .LATENCY_O(lat_o),
    .LOAD_BUSY_O(busy_o), .BURST_ACT_O(act_o), .BURST_COL_O(col_o));
  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // expected column: wrap inside the aligned block, xor when interleaved
  function automatic smrb_col_t colx(input smrb_col_t s, input int i);
    smrb_col_t m;
    m = (cur[2:0] == 3'h7) ? 9'h1FF : 9'((1 << cur[2:0]) - 1);
    return (s & ~m) | ((cur[3] ? (s ^ 9'(i)) : (s + 9'(i))) & m);
  endfunction
  // outputs are compared in order against the notes of the driver
  always @(negedge clk) begin
    if (!rst && mode_o !== last_mode) begin
      if (mq.size() > 0) chk(mode_o, mq.pop_front());
      else chk(mode_o, last_mode);
      last_mode = mode_o;
    end
    if (!rst && act_o === 1'b1) begin
      if (cq.size() > 0) chk(13'(col_o), 13'(cq.pop_front()));
      else if (!pg) chk(13'(col_o), 13'h1FFF);
    end
  end
  // bounded wait for all notes to be used, load busy to clear and, unless ign is set, the burst to end
  task automatic settle(input logic ign);
    int n;
    n = 0;
    while ((mq.size() + cq.size() > 0 || busy_o !== 1'b0 ||
            (act_o !== 1'b0 && !ign)) && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n == 300) begin
      num_errors++;
      report_and_stop();
    end
    repeat (3) @(negedge clk);
  endtask
  task automatic access(input logic wr);
    smrb_col_t s;
    int        len;
    s = lfsr[8:0];
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    len = (cur[2:0] == 3'h7) ? 5 : (1 << cur[2:0]);
    if (wr && cur[9]) len = 1;
    for (int i = 0; i < len; i++) cq.push_back(colx(s, i));
    u_ctl.issue({3'h2, ~wr}, {4'h0, s});
    settle(pg);
    if (pg) begin
      stop = 1'b1;
      @(negedge clk);
      stop = 1'b0;
      settle(1'b0);
    end
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    // power-up load, then lengths 1, 2, 4, 8 and page, both orderings, latencies 2 and 3
    foreach (modes[k]) begin
      cur = modes[k];
      mq.push_back(cur);
      u_ctl.issue(4'h0, cur);
      settle(1'b0);
      chk(13'(lat_o), (cur[6:4] == 3'h2) ? 13'h2 : 13'h3);
      pg = (cur[2:0] == 3'h7);
      access(1'b0);
      access(1'b1);
    end
    // a load issued while the clock enable is low must be lost
    ce = 1'b0;
    u_ctl.issue(4'h0, 13'h0155);
    repeat (3) @(negedge clk);
    ce = 1'b1;
    settle(1'b0);
    chk(mode_o, cur);
    // deselected load pattern must leave the setting alone
    u_ctl.issue(4'h8, 13'h0155);
    settle(1'b0);
    chk(mode_o, cur);
    report_and_stop();
  end
endmodule // sdram_mode_register_burst_bench
